// *** audio_smi_pkg.sv ***
// constants and types for the audio smi second-level status block
// How it works
// - bits 15 to 8 of both status views always read zero
// - bit 7 sets on engine 5 end-of-page rise while engine 5 enabled
// - bit 6 sets on engine 4 end-of-page rise while engine 4 enabled
// - bit 5 sets on engine 3 end-of-page rise while engine 3 enabled
// - bit 4 sets on engine 2 end-of-page rise while engine 2 enabled
// - bit 3 sets on engine 1 end-of-page rise while engine 1 enabled
// - bit 2 sets on engine 0 end-of-page rise while engine 0 enabled
// - bit 1 sets on enabled codec serial or codec pin interrupt
// - bit 0 sets on an io trap; detail sits in third-level register
// - engine bit clears only once its end-of-page bit is already clear
// - mirror at 12h reads status without changing status or smi
// - any set status bit shows in the top-level status bit
// - reading 10h clears status bits and the top-level bit with them
// - trap bit clears only after third-level trap status is clear
package audio_smi_pkg;
  localparam int ENGINES = 6;
  localparam int STAT_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS_CLR = 8'h10;
  localparam logic [7:0] OFS_STATUS_MIRROR = 8'h12;
  localparam logic [7:0] OFS_TRAP_THIRD = 8'h14;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] USED_MASK = 16'h00ff;
  localparam int BIT_TRAP = 0;
  localparam int BIT_CODEC = 1;
  localparam int BIT_ENGINE0 = 2;
  localparam logic [5:0] ENGINE_RESET = 6'h00;

  typedef struct packed {
    logic [5:0] enable;
    logic [5:0] end_of_page;
  } engine_src_t;

  typedef struct packed {
    logic serial_int;
    logic serial_int_en;
    logic pin_int;
    logic pin_int_en;
  } codec_src_t;

  typedef struct packed {
    logic event_pulse;
    logic third_level_set;
  } trap_src_t;

  typedef struct packed {
    logic rd_en;
    logic [7:0] rd_addr;
  } rd_req_t;

  typedef struct packed {
    logic rd_valid;
    logic [15:0] rd_data;
  } rd_rsp_t;
endpackage : audio_smi_pkg

// *** audio_smi_second_level_status.sv ***
// audio_smi_second_level_status status with clear-on-read and mirror views
`timescale 1ns/1ns
module audio_smi_second_level_status (
  input wire logic clk,
  input wire logic reset,
  input wire audio_smi_pkg::engine_src_t engine,
  input wire audio_smi_pkg::codec_src_t codec,
  input wire audio_smi_pkg::trap_src_t trap,
  input wire audio_smi_pkg::rd_req_t req,
  output audio_smi_pkg::rd_rsp_t rsp,
  output logic top_level_status,
  output logic smi_req
);
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [5:0] eop_prev_r;
  logic [5:0] eop_prev_nxt;
  logic codec_prev_r;
  logic codec_prev_nxt;
  audio_smi_pkg::rd_rsp_t rsp_r;
  audio_smi_pkg::rd_rsp_t rsp_nxt;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [5:0] engine_rise;
  logic codec_level;
  logic rd_clr;
  logic rd_mirror;
  logic top_r;
  logic top_nxt;
  logic smi_r;
  logic smi_nxt;

  // event detection
  always_comb begin
    engine_rise = engine.end_of_page & ~eop_prev_r & engine.enable;
    codec_level = (codec.serial_int & codec.serial_int_en) |
                  (codec.pin_int & codec.pin_int_en);
    set_vec = 16'h0000;
    for (int i = 0; i < audio_smi_pkg::ENGINES; i++) begin
      set_vec[audio_smi_pkg::BIT_ENGINE0 + i] = engine_rise[i];
    end
    set_vec[audio_smi_pkg::BIT_CODEC] = codec_level & ~codec_prev_r;
    set_vec[audio_smi_pkg::BIT_TRAP] = trap.event_pulse;
  end

  // edge history of the level sources
  always_comb begin
    eop_prev_nxt = engine.end_of_page;
    codec_prev_nxt = codec_level;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      eop_prev_r <= audio_smi_pkg::ENGINE_RESET;
      codec_prev_r <= 1'b0;
    end else begin
      eop_prev_r <= eop_prev_nxt;
      codec_prev_r <= codec_prev_nxt;
    end
  end

  // read decode and clear mask
  always_comb begin
    rd_clr = req.rd_en && (req.rd_addr == audio_smi_pkg::OFS_STATUS_CLR);
    rd_mirror = req.rd_en &&
                (req.rd_addr == audio_smi_pkg::OFS_STATUS_MIRROR);
    clr_vec = 16'h0000;
    if (rd_clr) begin
      clr_vec = audio_smi_pkg::USED_MASK;
      for (int i = 0; i < audio_smi_pkg::ENGINES; i++) begin
        if (engine.end_of_page[i]) begin
          clr_vec[audio_smi_pkg::BIT_ENGINE0 + i] = 1'b0;
        end
      end
      if (trap.third_level_set) begin
        clr_vec[audio_smi_pkg::BIT_TRAP] = 1'b0;
      end
    end
  end

  // status next value, set wins over clear
  always_comb begin
    status_nxt = ((status_r & ~clr_vec) | set_vec) &
                 audio_smi_pkg::USED_MASK;
    top_nxt = |status_nxt;
    smi_nxt = |status_nxt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_r <= audio_smi_pkg::STATUS_RESET;
      top_r <= 1'b0;
      smi_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      top_r <= top_nxt;
      smi_r <= smi_nxt;
    end
  end

  // read response, data taken before the clear lands
  always_comb begin
    rsp_nxt.rd_valid = req.rd_en;
    rsp_nxt.rd_data = 16'h0000;
    if (rd_clr || rd_mirror) begin
      rsp_nxt.rd_data = status_r & audio_smi_pkg::USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign rsp = rsp_r;
  assign top_level_status = top_r;
  assign smi_req = smi_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_reserved_zero: assert property (
    status_r[15:8] == 8'h00 && rsp.rd_data[15:8] == 8'h00)
    else $error("reserved status bits not zero");

  chk_engine5_set: assert property (
    engine.enable[5] && engine.end_of_page[5] && !eop_prev_r[5]
    |=> status_r[7])
    else $error("engine 5 event not recorded");

  chk_engine4_set: assert property (
    engine.enable[4] && engine.end_of_page[4] && !eop_prev_r[4]
    |=> status_r[6])
    else $error("engine 4 event not recorded");

  chk_engine3_set: assert property (
    engine.enable[3] && engine.end_of_page[3] && !eop_prev_r[3]
    |=> status_r[5])
    else $error("engine 3 event not recorded");

  chk_engine2_set: assert property (
    engine.enable[2] && engine.end_of_page[2] && !eop_prev_r[2]
    |=> status_r[4])
    else $error("engine 2 event not recorded");

  chk_engine1_set: assert property (
    engine.enable[1] && engine.end_of_page[1] && !eop_prev_r[1]
    |=> status_r[3])
    else $error("engine 1 event not recorded");

  chk_engine0_set: assert property (
    engine.enable[0] && engine.end_of_page[0] && !eop_prev_r[0]
    |=> status_r[2])
    else $error("engine 0 event not recorded");

  chk_codec_set: assert property (
    !codec_prev_r && ((codec.serial_int && codec.serial_int_en) ||
    (codec.pin_int && codec.pin_int_en)) |=> status_r[1])
    else $error("codec interrupt not recorded");

  chk_codec_gated: assert property (
    !status_r[1] && !codec.serial_int_en && !codec.pin_int_en
    |=> !status_r[1])
    else $error("codec bit set while both sources gated");

  chk_trap_set: assert property (
    trap.event_pulse |=> status_r[0])
    else $error("io trap not recorded");

  chk_eop_holds: assert property (
    status_r[2] && engine.end_of_page[0] |=> status_r[2])
    else $error("engine bit cleared while end of page set");

  chk_mirror_keep: assert property (
    rd_mirror |=> status_r == $past(status_r | set_vec) &&
    rsp.rd_data == $past(status_r))
    else $error("mirror read disturbed status");

  chk_top_level: assert property (
    top_level_status == (status_r != 16'h0000))
    else $error("top level status mismatch");

  chk_read_clear: assert property (
    rd_clr && set_vec == 16'h0000 && engine.end_of_page == 6'h00 &&
    !trap.third_level_set |=> status_r == 16'h0000 && !top_level_status
    && rsp.rd_valid)
    else $error("clearing read left status set");

  chk_trap_holds: assert property (
    status_r[0] && trap.third_level_set |=> status_r[0])
    else $error("trap bit cleared before third level");

  chk_smi_level: assert property (
    status_r != 16'h0000 && !rd_clr |=> smi_req [*1])
    else $error("smi dropped with status set");

  chk_engine5_hold: assert property (
    status_r[7] && engine.end_of_page[5] |=> status_r[7])
    else $error("engine 5 bit cleared while end of page set");

  chk_engine4_hold: assert property (
    status_r[6] && engine.end_of_page[4] |=> status_r[6])
    else $error("engine 4 bit cleared while end of page set");

  chk_engine3_hold: assert property (
    status_r[5] && engine.end_of_page[3] |=> status_r[5])
    else $error("engine 3 bit cleared while end of page set");

  chk_engine2_hold: assert property (
    status_r[4] && engine.end_of_page[2] |=> status_r[4])
    else $error("engine 2 bit cleared while end of page set");

  chk_engine1_hold: assert property (
    status_r[3] && engine.end_of_page[1] |=> status_r[3])
    else $error("engine 1 bit cleared while end of page set");

  chk_engine5_gated: assert property (
    !status_r[7] && !engine.enable[5] |=> !status_r[7])
    else $error("engine 5 bit set while engine disabled");

  chk_engine4_gated: assert property (
    !status_r[6] && !engine.enable[4] |=> !status_r[6])
    else $error("engine 4 bit set while engine disabled");

  chk_engine3_gated: assert property (
    !status_r[5] && !engine.enable[3] |=> !status_r[5])
    else $error("engine 3 bit set while engine disabled");

  chk_engine2_gated: assert property (
    !status_r[4] && !engine.enable[2] |=> !status_r[4])
    else $error("engine 2 bit set while engine disabled");

  chk_engine1_gated: assert property (
    !status_r[3] && !engine.enable[1] |=> !status_r[3])
    else $error("engine 1 bit set while engine disabled");

  chk_engine0_gated: assert property (
    !status_r[2] && !engine.enable[0] |=> !status_r[2])
    else $error("engine 0 bit set while engine disabled");

  chk_engine_clear: assert property (
    rd_clr && engine.end_of_page == 6'h00 |=> status_r[7:2] == 6'h00)
    else $error("engine bits survived a clearing read");

  chk_codec_clear: assert property (
    rd_clr && !set_vec[1] |=> !status_r[1])
    else $error("codec bit survived a clearing read");

  chk_trap_clear: assert property (
    rd_clr && !trap.third_level_set && !trap.event_pulse
    |=> !status_r[0])
    else $error("trap bit survived a clearing read");

  chk_codec_one_shot: assert property (
    codec_prev_r && !status_r[1] |=> !status_r[1])
    else $error("codec bit set on a steady level");

  chk_codec_keep: assert property (
    status_r[1] && !rd_clr |=> status_r[1])
    else $error("codec bit dropped without a clearing read");

  chk_trap_only_event: assert property (
    !status_r[0] && !trap.event_pulse |=> !status_r[0])
    else $error("trap bit set without a trap event");

  chk_mirror_smi: assert property (
    rd_mirror && smi_req |=> smi_req)
    else $error("mirror read dropped the smi request");

  chk_mirror_valid: assert property (
    rd_mirror |=> rsp.rd_valid)
    else $error("mirror read not answered");

  chk_clear_data: assert property (
    rd_clr |=> rsp.rd_valid && rsp.rd_data == $past(status_r))
    else $error("clearing read returned wrong data");

  chk_unmapped_zero: assert property (
    req.rd_en && !rd_clr && !rd_mirror
    |=> rsp.rd_valid && rsp.rd_data == 16'h0000)
    else $error("unmapped read returned data");

  chk_valid_once: assert property (
    !req.rd_en |=> !rsp.rd_valid)
    else $error("read answer without a read");

  chk_smi_drop: assert property (
    rd_clr && set_vec == 16'h0000 && engine.end_of_page == 6'h00 &&
    !trap.third_level_set |=> !smi_req)
    else $error("smi held after every status bit cleared");

  chk_top_follows: assert property (
    set_vec != 16'h0000 |=> top_level_status)
    else $error("top level status missed a new event");

  chk_top_hold: assert property (
    top_level_status && !rd_clr |=> top_level_status)
    else $error("top level status dropped without a clear");

  chk_smi_raise: assert property (
    set_vec != 16'h0000 |=> smi_req)
    else $error("smi not raised on a new event");
endmodule : audio_smi_second_level_status

// *** audio_smi_second_level_status_bench.sv ***
// random bench comparing the status block with a model
`timescale 1ns/1ns
module audio_smi_second_level_status_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic quiet = 1'b0;
  audio_smi_pkg::engine_src_t engine = '0;
  audio_smi_pkg::codec_src_t codec = '0;
  audio_smi_pkg::trap_src_t trap = '0;
  audio_smi_pkg::rd_req_t req = '0;
  audio_smi_pkg::rd_rsp_t rsp;
  logic top_level_status;
  logic smi_req;
  logic [31:0] seed = 32'h0000_0019;
  logic [15:0] m_stat, m_nxt, m_data;
  logic [5:0] m_eop;
  logic m_cod, m_valid, cod;
  int entries, e_cnt, e_dly, bad_count, checks;
  always #50 clk = ~clk;
  audio_smi_second_level_status uut (.clk(clk), .reset(reset),
    .engine(engine), .codec(codec), .trap(trap), .req(req), .rsp(rsp),
    .top_level_status(top_level_status), .smi_req(smi_req));
  smi_core_model far (.clk(clk), .reset(reset), .smi_req(smi_req),
    .top_level_status(top_level_status), .entries(entries));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    if (!run) begin
      m_stat = '0;
      m_eop = '0;
      m_cod = 1'b0;
      m_valid = 1'b0;
      e_cnt = 0;
      e_dly = 0;
      engine <= '0;
      codec <= '0;
      trap <= '0;
      req <= '0;
    end else begin
      check(rsp.rd_valid, m_valid);
      if (m_valid) check(rsp.rd_data, m_data);
      check(smi_req, |m_stat);
      check(top_level_status, |m_stat);
      check(entries[15:0], e_dly[15:0]);
      e_dly = e_cnt;
      m_valid = req.rd_en;
      m_data = (req.rd_addr == 8'h10 || req.rd_addr == 8'h12) ? m_stat : '0;
      m_nxt = m_stat;
      if (req.rd_en && req.rd_addr == 8'h10)
        m_nxt = m_stat & {8'h00, engine.end_of_page, 1'b0,
          trap.third_level_set};
      cod = codec.serial_int & codec.serial_int_en
        | codec.pin_int & codec.pin_int_en;
      m_nxt[7:2] = m_nxt[7:2]
        | (engine.enable & engine.end_of_page & ~m_eop);
      m_nxt[1] = m_nxt[1] | (cod & ~m_cod);
      m_nxt[0] = m_nxt[0] | trap.event_pulse;
      if (|m_nxt && !(|m_stat)) e_cnt++;
      m_stat = m_nxt;
      m_eop = engine.end_of_page;
      m_cod = cod;
      seed = xs(seed);
      engine <= {seed[5:0], quiet ?
        (engine.end_of_page & {6{seed[29]}}) |
        (seed[11:6] & seed[17:12] & {6{seed[30] & seed[31]}}) :
        engine.end_of_page ^ (seed[11:6] & seed[17:12])};
      codec <= seed[21:18];
      trap <= {seed[22] & seed[23], seed[24] & ~quiet};
      req <= {seed[25] & seed[26], 4'h1, 1'b0, seed[28:27], 1'b0};
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      reset <= 1'b0;
      quiet <= (p == 1);
      run <= 1'b1;
      repeat (1500) @(posedge clk);
      $display("random phase %0d ended", p);
      run <= 1'b0;
      reset <= 1'b1;
      repeat (8) @(posedge clk);
    end
    final_report();
  end
endmodule : audio_smi_second_level_status_bench

// *** smi_core_model.sv ***
// processor-side smi model counting handler entries
`timescale 1ns/1ns
module smi_core_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic smi_req,
  input wire logic top_level_status,
  output int entries
);
  logic prev_r;
  always @(posedge clk) begin
    if (reset) begin
      prev_r <= 1'b0;
      entries <= 0;
    end else begin
      prev_r <= smi_req;
      if (smi_req && !prev_r && top_level_status) entries <= entries + 1;
    end
  end
endmodule : smi_core_model
